//--- rtl/uwtb_baud_timer.sv
// Timer 1 in 8-bit auto-reload form with a hidden receive copy.
// Assumes extOscLvl and pinLvl are already synchronised to clk.
`timescale 1ns/100ps
module uwtb_baud_timer import uwtb_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire uwtb_tcfg_t  tcfg,
  input  wire logic [7:0]  reloadByte,
  input  wire logic        lowWrEn,
  input  wire logic [7:0]  lowWrData,
  input  wire logic        rxRestart,
  input  wire logic        extOscLvl,
  input  wire logic        pinLvl,
  output logic [7:0]       lowCount,
  output uwtb_ticks_t      ticks
);
  logic [5:0] preCnt_r;
  logic [5:0] preLast;
  logic [2:0] oscCnt_r;
  logic       oscPrev_r;
  logic       pinPrev_r;
  logic [7:0] txCnt_r;
  logic [7:0] rxCnt_r;
  logic       txPhase_r;
  logic       rxPhase_r;
  logic       inc;
  logic       oscRise;
  logic       txOvf;
  logic       rxOvf;

  // ---------------------------------------------------------------
  // Clock source selection
  // ---------------------------------------------------------------
  always_comb
  begin
    case (tcfg.sel)
      CLK_DIV4:  preLast = DIV4_LAST;
      CLK_DIV12: preLast = DIV12_LAST;
      CLK_DIV48: preLast = DIV48_LAST;
      default:   preLast = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
      preCnt_r <= '0;
    else if (preCnt_r >= preLast)
      preCnt_r <= '0;
    else
      preCnt_r <= preCnt_r + 6'h01;

  assign oscRise = extOscLvl & ~oscPrev_r;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      oscPrev_r <= 1'b1;
      pinPrev_r <= 1'b1;
      oscCnt_r  <= '0;
    end
    else
    begin
      oscPrev_r <= extOscLvl;
      pinPrev_r <= pinLvl;
      if (oscRise)
        oscCnt_r <= oscCnt_r + 3'h1;
    end

  always_comb
  begin
    case (tcfg.sel)
      CLK_SYS:   inc = 1'b1;
      CLK_DIV4,
      CLK_DIV12,
      CLK_DIV48: inc = (preCnt_r == preLast);
      CLK_OSC8:  inc = oscRise & (oscCnt_r == OSC8_LAST);
      CLK_T1PIN: inc = pinPrev_r & ~pinLvl;
      default:   inc = 1'b0;
    endcase
    inc = inc & tcfg.run;
  end

  // ---------------------------------------------------------------
  // Counters and halving
  // ---------------------------------------------------------------
  assign txOvf = inc & (txCnt_r == CNT_TOP);
  assign rxOvf = inc & (rxCnt_r == CNT_TOP);

  always_ff @(posedge clk or posedge rst)
    if (rst)
      txCnt_r <= '0;
    else if (lowWrEn)
      txCnt_r <= lowWrData;
    else if (txOvf)
      txCnt_r <= reloadByte;
    else if (inc)
      txCnt_r <= txCnt_r + 8'h01;

  // Hidden copy; only the start edge and overflow reload it
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rxCnt_r <= '0;
    else if (rxRestart)
      rxCnt_r <= reloadByte;
    else if (rxOvf)
      rxCnt_r <= reloadByte;
    else if (inc)
      rxCnt_r <= rxCnt_r + 8'h01;

  // First receive overflow after a restart lands mid start bit
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      txPhase_r <= 1'b0;
      rxPhase_r <= 1'b0;
    end
    else
    begin
      if (txOvf)
        txPhase_r <= ~txPhase_r;
      if (rxRestart)
        rxPhase_r <= 1'b0;
      else if (rxOvf)
        rxPhase_r <= ~rxPhase_r;
    end

  assign ticks.txBit    = txOvf & txPhase_r;
  assign ticks.rxSample = rxOvf & ~rxPhase_r & ~rxRestart;
  assign lowCount       = txCnt_r;
endmodule

//--- rtl/uwtb_pkg.sv
// Shared constants and types for the serial port with timer baud generation.
// Assumes a 32-bit classic Wishbone master and one system clock.
package uwtb_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_DATA   = 5'h04;
  localparam logic [4:0] ADDR_TCFG   = 5'h08;
  localparam logic [4:0] ADDR_RELOAD = 5'h0c;
  localparam logic [4:0] ADDR_LOW    = 5'h10;
  localparam logic [4:0] ADDR_STAT   = 5'h14;
  localparam logic [4:0] ADDR_MASK   = 5'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_SMODE = 7;
  localparam int CTL_RSVD  = 6;
  localparam int CTL_FILT  = 5;
  localparam int CTL_REN   = 4;
  localparam int CTL_TX9   = 3;
  localparam int CTL_RX9   = 2;
  localparam int CTL_TDONE = 1;
  localparam int CTL_RDONE = 0;
  localparam int TCFG_RUN  = 0;
  localparam int TCFG_SELL = 1;
  localparam int TCFG_SELH = 3;
  localparam int STAT_TX   = 0;
  localparam int STAT_RX   = 1;
  localparam int STAT_W    = 2;

  localparam logic [7:0] CTL_RSVD_VAL = 8'h40;
  localparam logic [7:0] CNT_TOP      = 8'hff;
  localparam logic [5:0] DIV4_LAST    = 6'h03;
  localparam logic [5:0] DIV12_LAST   = 6'h0b;
  localparam logic [5:0] DIV48_LAST   = 6'h2f;
  localparam logic [2:0] OSC8_LAST    = 3'h7;
  localparam logic [3:0] DATA_LAST    = 4'h7;
  localparam logic [3:0] TXLEN8       = 4'ha;
  localparam logic [3:0] TXLEN9       = 4'hb;

  typedef enum logic [2:0] {
    CLK_SYS   = 3'b000,
    CLK_DIV4  = 3'b001,
    CLK_DIV12 = 3'b010,
    CLK_DIV48 = 3'b011,
    CLK_OSC8  = 3'b100,
    CLK_T1PIN = 3'b101
  } uwtb_clksel_t;

  typedef struct packed {
    logic         run;
    uwtb_clksel_t sel;
  } uwtb_tcfg_t;

  typedef struct packed {
    logic txBit;
    logic rxSample;
  } uwtb_ticks_t;

endpackage

//--- rtl/uwtb_sync.sv
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes inputs change slowly relative to clk.
`timescale 1ns/100ps
module uwtb_sync import uwtb_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] synced
);
  logic [W-1:0] meta_r;

  // Idle-high reset value suits the receive line and pins alike
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      meta_r <= '1;
      synced <= '1;
    end
    else
    begin
      meta_r <= async;
      synced <= meta_r;
    end
endmodule

//--- rtl/uwtb_top.sv
// Full-duplex serial port, 8-bit and 9-bit framing, timer-driven baud.
// Assumes a classic Wishbone master on clk; rxd, extOscClk, timerPin are async.
`timescale 1ns/100ps

// What this block does
// - Full-duplex async port offering only framing modes 1 and 3.
// - Completed receive byte is buffered so the next reception can start.
// - Writing the data buffer loads the transmitter and starts sending.
// - Reading the data buffer returns the received byte, never transmit data.
// - Enabled interrupt requested when hardware sets transmit-done or receive-done.
// - Hardware never clears transmit-done or receive-done flags itself.
// - Baud from timer 1 in 8-bit auto-reload; transmit uses its low byte.
// - Receive bit clock uses a hidden copy of the timer low byte.
// - Both counters' overflows are halved; baud is half overflow rate.
// - Receive copy counts only with timer enabled and shares the reload.
// - Start edge on receive pin forces immediate receive counter reload.
// - Timer clock: system, divided by 4, 12, 48, oscillator/8, or pin.
// - 8-bit frame: start, eight data bits LSB first, stop.
// - 9-bit frame adds ninth bit; received ninth bit captured, stop ignored.
// - Transmit-done flag sets at start of the stop bit.
// - Load byte only if receive-done clear and multiprocessor check passes.
module uwtb_top import uwtb_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        extOscClk,
  input  wire logic        timerPin,
  output logic             irq
);

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP  = 3'b100
  } uwtb_rxst_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_BUSY = 1'b1
  } uwtb_txst_t;

  logic              smode_r;
  logic              mpf_r;
  logic              ren_r;
  logic              txNinth_r;
  logic              rxNinth_r;
  logic              txDone_r;
  logic              rxDone_r;
  uwtb_tcfg_t        tcfg_r;
  logic [7:0]        reload_r;
  logic [STAT_W-1:0] stat_r;
  logic [STAT_W-1:0] mask_r;
  logic [7:0]        rxBuf_r;
  logic [7:0]        rxShift_r;
  logic              ninth_r;
  logic [3:0]        rxCnt_r;
  uwtb_rxst_t        rxSt_r;
  logic              rxPrev_r;
  logic [10:0]       txShift_r;
  logic [3:0]        txLeft_r;
  uwtb_txst_t        txSt_r;
  logic [2:0]        syncIn;
  logic [2:0]        syncOut;
  logic              rxLvl;
  logic              req;
  logic              wrEn;
  logic              rdEn;
  logic [4:0]        adr;
  logic [31:0]       rdData;
  logic              rxStart;
  logic              rxCommit;
  logic              rxCheck;
  logic              txStopNow;
  logic [7:0]        lowCount;
  uwtb_ticks_t       ticks;
  logic [STAT_W-1:0] events;

  // ---------------------------------------------------------------
  // Pin synchronisation and baud timer
  // ---------------------------------------------------------------
  assign syncIn = {timerPin, extOscClk, rxd};

  uwtb_sync #(.W(3)) u_sync (
    .clk    (clk),
    .rst    (rst),
    .async  (syncIn),
    .synced (syncOut)
  );

  assign rxLvl = syncOut[0];

  uwtb_baud_timer u_timer (
    .clk        (clk),
    .rst        (rst),
    .tcfg       (tcfg_r),
    .reloadByte (reload_r),
    .lowWrEn    (wrEn && adr == ADDR_LOW),
    .lowWrData  (wb_dat_i[7:0]),
    .rxRestart  (rxStart),
    .extOscLvl  (syncOut[1]),
    .pinLvl     (syncOut[2]),
    .lowCount   (lowCount),
    .ticks      (ticks)
  );

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // Registers are a byte wide, so only lane 0 carries a write
  assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign adr  = wb_adr_i[4:0];
  assign wrEn = req & wb_we_i & wb_sel_i[0];
  assign rdEn = req & ~wb_we_i;

  always_comb
  begin
    rdData = '0;
    case (adr)
      ADDR_CTRL:
      begin
        rdData[CTL_SMODE] = smode_r;
        rdData[CTL_RSVD]  = CTL_RSVD_VAL[CTL_RSVD];
        rdData[CTL_FILT]  = mpf_r;
        rdData[CTL_REN]   = ren_r;
        rdData[CTL_TX9]   = txNinth_r;
        rdData[CTL_RX9]   = rxNinth_r;
        rdData[CTL_TDONE] = txDone_r;
        rdData[CTL_RDONE] = rxDone_r;
      end
      ADDR_DATA:   rdData[7:0] = rxBuf_r;
      ADDR_TCFG:
      begin
        rdData[TCFG_RUN]            = tcfg_r.run;
        rdData[TCFG_SELH:TCFG_SELL] = tcfg_r.sel;
      end
      ADDR_RELOAD: rdData[7:0] = reload_r;
      ADDR_LOW:    rdData[7:0] = lowCount;
      ADDR_STAT:   rdData[STAT_W-1:0] = stat_r;
      ADDR_MASK:   rdData[STAT_W-1:0] = mask_r;
      default:     rdData = '0;
    endcase
  end

  // Answer one cycle after the request; unmapped reads return zero
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= req;
      if (rdEn)
        wb_dat_o <= rdData;
    end

  // ---------------------------------------------------------------
  // Control and timer configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      smode_r  <= 1'b0;
      mpf_r     <= 1'b0;
      ren_r     <= 1'b0;
      txNinth_r <= 1'b0;
      tcfg_r   <= '{run: 1'b0, sel: CLK_SYS};
      reload_r <= '0;
      mask_r   <= '0;
    end
    else if (wrEn)
    begin
      case (adr)
        ADDR_CTRL:
        begin
          smode_r <= wb_dat_i[CTL_SMODE];
          mpf_r     <= wb_dat_i[CTL_FILT];
          ren_r     <= wb_dat_i[CTL_REN];
          txNinth_r <= wb_dat_i[CTL_TX9];
        end
        ADDR_TCFG:
        begin
          tcfg_r.run <= wb_dat_i[TCFG_RUN];
          tcfg_r.sel <= uwtb_clksel_t'(wb_dat_i[TCFG_SELH:TCFG_SELL]);
        end
        ADDR_RELOAD: reload_r <= wb_dat_i[7:0];
        ADDR_MASK:   mask_r   <= wb_dat_i[STAT_W-1:0];
        default:     mask_r   <= mask_r;
      endcase
    end

  // Hardware set beats a same-cycle software clear
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      txDone_r  <= 1'b0;
      rxDone_r  <= 1'b0;
      rxNinth_r <= 1'b0;
    end
    else
    begin
      if (txStopNow)
        txDone_r <= 1'b1;
      else if (wrEn && adr == ADDR_CTRL)
        txDone_r <= wb_dat_i[CTL_TDONE];
      if (rxCommit)
        rxDone_r <= 1'b1;
      else if (wrEn && adr == ADDR_CTRL)
        rxDone_r <= wb_dat_i[CTL_RDONE];
      if (rxCommit)
        rxNinth_r <= smode_r ? ninth_r : rxLvl;
      else if (wrEn && adr == ADDR_CTRL)
        rxNinth_r <= wb_dat_i[CTL_RX9];
    end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  assign events[STAT_TX] = txStopNow;
  assign events[STAT_RX] = rxCommit;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      stat_r <= '0;
      irq    <= 1'b0;
    end
    else
    begin
      stat_r <= ((rdEn && adr == ADDR_STAT) ? '0 : stat_r) | events;
      irq    <= |(stat_r & mask_r);
    end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  assign txStopNow = (txSt_r == TX_BUSY) & ticks.txBit & (txLeft_r == 4'h1);

  // A write while busy restarts the frame with the new byte
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      txSt_r    <= TX_IDLE;
      txShift_r <= '1;
      txLeft_r  <= '0;
      txd       <= 1'b1;
    end
    else if (wrEn && adr == ADDR_DATA)
    begin
      txSt_r    <= TX_BUSY;
      txShift_r <= {1'b1, smode_r ? txNinth_r : 1'b1, wb_dat_i[7:0], 1'b0};
      txLeft_r  <= smode_r ? TXLEN9 : TXLEN8;
    end
    else if (ticks.txBit)
    begin
      case (txSt_r)
        TX_BUSY:
        begin
          if (txLeft_r == 4'h0)
            txSt_r <= TX_IDLE;
          else
          begin
            txd       <= txShift_r[0];
            txShift_r <= {1'b1, txShift_r[10:1]};
            txLeft_r  <= txLeft_r - 4'h1;
          end
        end
        default: txSt_r <= TX_IDLE;
      endcase
    end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  assign rxStart  = (rxSt_r == RX_IDLE) & ren_r & tcfg_r.run & rxPrev_r & ~rxLvl;
  assign rxCheck  = smode_r ? ninth_r : rxLvl;
  assign rxCommit = (rxSt_r == RX_STOP) & ticks.rxSample & ~rxDone_r & (~mpf_r | rxCheck);

  always_ff @(posedge clk or posedge rst)
    if (rst)
      rxPrev_r <= 1'b1;
    else
      rxPrev_r <= rxLvl;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      rxBuf_r <= '0;
    else if (rxCommit)
      rxBuf_r <= rxShift_r;

  // Stalls mid-frame if the timer is stopped; frame resumes on restart
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rxSt_r    <= RX_IDLE;
      rxShift_r <= '0;
      ninth_r   <= 1'b0;
      rxCnt_r   <= '0;
    end
    else if (rxStart)
      rxSt_r <= RX_START;
    else if (ticks.rxSample)
    begin
      case (rxSt_r)
        RX_START:
        begin
          rxCnt_r <= '0;
          rxSt_r  <= rxLvl ? RX_IDLE : RX_DATA;
        end
        RX_DATA:
        begin
          rxShift_r <= {rxLvl, rxShift_r[7:1]};
          rxCnt_r   <= rxCnt_r + 4'h1;
          if (rxCnt_r == DATA_LAST)
            rxSt_r <= smode_r ? RX_NINTH : RX_STOP;
        end
        RX_NINTH:
        begin
          ninth_r <= rxLvl;
          rxSt_r  <= RX_STOP;
        end
        RX_STOP: rxSt_r <= RX_IDLE;
        default: rxSt_r <= RX_IDLE;
      endcase
    end
endmodule

//--- tb/test_uwtb_top.sv
// Self-checking bench for uwtb_top with the remote model on its serial pins.
// Assumes the remote bit time equals two timer overflows at RELOAD.
`timescale 1ns/100ps
module test_uwtb_top import uwtb_pkg::*; ;
  localparam logic [7:0] RELOAD = 8'hf0;
  localparam int         BIT    = 2 * (256 - int'(RELOAD));

  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic        wb_cyc_i   = 1'b0;
  logic        wb_stb_i   = 1'b0;
  logic        wb_we_i    = 1'b0;
  logic [31:0] wb_adr_i   = 32'h0;
  logic [3:0]  wb_sel_i   = 4'hf;
  logic [31:0] wb_dat_i   = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        rxd;
  logic        txd;
  logic        irq;
  logic        nine       = 1'b0;
  logic [3:0]  tick       = 4'h0;
  logic [7:0]  lastRx     = 8'h00;
  logic        haveRx     = 1'b0;
  int          badCount   = 0;
  int          checkCount = 0;

  always #25 clk = ~clk;
  always @(posedge clk) tick <= tick + 4'h1;

  uwtb_top dut_u (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxd, .txd,
    .extOscClk(tick[2]), .timerPin(tick[3]), .irq);
  uwtb_remote #(.BIT(BIT)) peer (.clk, .txd, .nineMode(nine), .rxd);

  // ----------
  // Bus and reporting
  // ----------
  task automatic results();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic timeout();
    $display("wrong value wait expected done seen timeout");
    badCount++;
    results();
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", what, e, g);
      badCount++;
    end
  endtask

  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {27'h0, a};
    wb_dat_i <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
      timeout();
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(what, e, q);
  endtask

  task automatic poll(input int b);
    logic [31:0] q;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, ADDR_CTRL, 8'h00, q);
      n++;
    end
    while (q[b] !== 1'b1 && n < 400);
    if (q[b] !== 1'b1)
      timeout();
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic test_regs();
    rd(ADDR_CTRL, 32'h40, "ctrl");
    rd(ADDR_TCFG, 32'h0, "tcfg");
    rd(ADDR_RELOAD, 32'h0, "reload");
    rd(ADDR_LOW, 32'h0, "low");
    rd(ADDR_STAT, 32'h0, "status");
    rd(ADDR_MASK, 32'h0, "mask");
    rd(5'h1c, 32'h0, "unmapped");
    wr(5'h1c, 8'hff);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 32'h40, "reserved");
    $display("test regs done");
  endtask

  task automatic test_rx(input logic [7:0] ctl, input logic [7:0] d, input logic n9,
                         input logic stp, input logic ld);
    logic [31:0] q;
    nine <= ctl[CTL_SMODE];
    // Receive-done set in ctl: leave the earlier flag standing
    if (!ctl[CTL_RDONE])
      wr(ADDR_CTRL, ctl);
    fork
      peer.send(d, n9, stp);
      begin
        repeat (3 * BIT) @(posedge clk);
        if (haveRx)
          rd(ADDR_DATA, {24'h0, lastRx}, "data during rx");
      end
    join
    repeat (4) @(posedge clk);
    if (ld)
    begin
      lastRx = d;
      haveRx = 1'b1;
    end
    wb(1'b0, ADDR_CTRL, 8'h00, q);
    chk("rx done", {31'h0, ld | ctl[CTL_RDONE]}, {31'h0, q[CTL_RDONE]});
    if (ld)
      chk("ninth rx", {31'h0, ctl[CTL_SMODE] ? n9 : stp}, {31'h0, q[CTL_RX9]});
    rd(ADDR_DATA, {24'h0, lastRx}, "rx data");
    rd(ADDR_STAT, {30'h0, ld, 1'b0}, "rx event");
    $display("rx case %h done", d);
  endtask

  task automatic test_tx(input logic n9mode, input logic [7:0] d, input logic n9);
    logic [31:0] q;
    int f0;
    int n;
    nine <= n9mode;
    wr(ADDR_CTRL, {n9mode, 3'b001, n9, 3'b000});
    f0 = peer.frames;
    wr(ADDR_DATA, d);
    poll(CTL_TDONE);
    chk("txd at done", 32'h1, {31'h0, txd});
    chk("frames at done", f0, peer.frames);
    n = 0;
    while (peer.frames == f0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 400)
      timeout();
    chk("tx byte", {24'h0, d}, {24'h0, peer.rxByte});
    chk("tx ninth", {31'h0, n9mode ? n9 : 1'b1}, {31'h0, peer.rxNinth});
    chk("tx stop", 32'h1, {31'h0, peer.rxStop});
    chk("irq", 32'h1, {31'h0, irq});
    rd(ADDR_STAT, 32'h1, "tx event");
    wb(1'b0, ADDR_CTRL, 8'h00, q);
    chk("tx done kept", 32'h1, {31'h0, q[CTL_TDONE]});
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(ADDR_DATA, {24'h0, lastRx}, "data read");
    $display("tx case %h done", d);
  endtask

  task automatic test_mask();
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    wr(ADDR_DATA, 8'h81);
    poll(CTL_TDONE);
    repeat (BIT) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADDR_MASK, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rd(ADDR_STAT, 32'h1, "status kept");
    repeat (2) @(posedge clk);
    chk("irq after read", 32'h0, {31'h0, irq});
    $display("test mask done");
  endtask

  // Reload zero widens the span so no delta below 256 wraps to equal
  task automatic test_clk();
    logic [31:0] a;
    logic [31:0] b;
    wr(ADDR_RELOAD, 8'h00);
    for (int s = 0; s < 7; s++)
    begin
      wr(ADDR_TCFG, s < 6 ? {4'h0, 3'(s), 1'b1} : 8'h00);
      wb(1'b0, ADDR_LOW, 8'h00, a);
      repeat (200) @(posedge clk);
      wb(1'b0, ADDR_LOW, 8'h00, b);
      chk("low moving", {31'h0, s < 6}, {31'h0, a !== b});
    end
    $display("test clk done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    wr(ADDR_RELOAD, RELOAD);
    wr(ADDR_TCFG, 8'h01);
    wr(ADDR_MASK, 8'h03);
    test_rx(8'h10, 8'h5a, 1'b0, 1'b1, 1'b1);
    test_rx(8'h11, 8'hc3, 1'b0, 1'b1, 1'b0);
    test_rx(8'hb0, 8'h11, 1'b0, 1'b1, 1'b0);
    test_rx(8'hb0, 8'h22, 1'b1, 1'b1, 1'b1);
    test_rx(8'h30, 8'h77, 1'b0, 1'b0, 1'b0);
    test_rx(8'h90, 8'he7, 1'b0, 1'b1, 1'b1);
    test_tx(1'b0, 8'h25, 1'b0);
    test_tx(1'b1, 8'hc3, 1'b0);
    test_tx(1'b1, 8'h3c, 1'b1);
    test_mask();
    test_clk();
    results();
  end
endmodule

bind uwtb_top uwtb_checker chk_u (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .txd, .irq);

//--- tb/uwtb_asserts.sv
// Port checker for uwtb_top: bus handshake, interrupt line, idle transmit.
// Assumes it is bound to uwtb_top and sees nothing but its ports.
`timescale 1ns/100ps
module uwtb_checker import uwtb_pkg::*; (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        txd,
  input wire logic        irq
);
  // ----------
  // Shadow of software writes
  // ----------
  logic       taken;
  logic       wrOk;
  logic [1:0] mask_r;
  logic       clrEv_r;
  logic       txSeen_r;

  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrOk  = taken && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk or posedge rst)
    if (rst)
      mask_r <= 2'h0;
    else if (wrOk && wb_adr_i[4:0] == ADDR_MASK)
      mask_r <= wb_dat_i[1:0];

  // Only a status read or a mask write may drop the line
  always_ff @(posedge clk or posedge rst)
    if (rst)
      clrEv_r <= 1'b0;
    else
      clrEv_r <= taken && (wb_adr_i[4:0] == ADDR_STAT && !wb_we_i
                           || wb_adr_i[4:0] == ADDR_MASK && wrOk);

  always_ff @(posedge clk or posedge rst)
    if (rst)
      txSeen_r <= 1'b0;
    else if (wrOk && wb_adr_i[4:0] == ADDR_DATA)
      txSeen_r <= 1'b1;

  // ----------
  // Assertions
  // ----------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  a_ack_next: assert property (taken |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_rdata_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  a_irq_masked: assert property (mask_r == 2'h0 |=> !irq)
    else $error("irq with all events masked");
  a_irq_rise: assert property ($rose(irq) |-> $past(mask_r) != 2'h0)
    else $error("irq rose while masked");
  a_irq_fall: assert property ($fell(irq) |-> $past(clrEv_r))
    else $error("irq dropped without software action");
  a_tx_idle: assert property (!txSeen_r |-> txd)
    else $error("txd left idle before any send");
endmodule

//--- tb/uwtb_remote.sv
// Remote transceiver model: decodes frames on txd, sends frames on rxd.
// Assumes BIT clk cycles per bit and nineMode naming the frame length.
`timescale 1ns/100ps
module uwtb_remote #(
  parameter int BIT = 32
) (
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic nineMode,
  output logic      rxd
);
  logic [9:0] got;
  logic [7:0] rxByte;
  logic       rxNinth;
  logic       rxStop;
  int         frames = 0;

  initial rxd = 1'b1;

  // Samples mid-bit, so sender skew below half a bit is tolerated
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 9 + nineMode; i++)
    begin
      repeat (BIT) @(posedge clk);
      got[i] = txd;
    end
    rxByte  = got[7:0];
    rxNinth = got[8];
    rxStop  = got[8 + nineMode];
    frames++;
  end

  task automatic send(input logic [7:0] b, input logic n9, input logic stp);
    logic [10:0] f;
    f = nineMode ? {stp, n9, b, 1'b0} : {1'b1, stp, b, 1'b0};
    for (int i = 0; i < 10 + nineMode; i++)
    begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask
endmodule
